// ==== rtl/omc_pkg.sv ====
// Purpose: shared constants for the module control pin pair
// Assumes: 50 MHz system clock on both ends
// Notes:   register maps of both ends live here
`default_nettype none
package omc_pkg;
  localparam int CLK_MHZ      = 50;          // system clock rate
  localparam int CNTL_US      = 100;         // least control pulse, us
  localparam int CNTL_CYC     = CNTL_US * CLK_MHZ; // 5000 cycles
  localparam int FILT_MARGIN  = 8;           // room for sync and output
  localparam int INIT_MS      = 2500;        // init bound after reset, ms
  localparam int INIT_CYC     = INIT_MS * 1000 * CLK_MHZ;
  localparam int MDC_HALF     = 8;           // host mdc half period
  localparam int PRE_ONES     = 32;          // preamble length
  localparam int LANES        = 4;           // optical lanes
  localparam int ALARMS       = 8;           // alarm sources
  // clause 45 opcodes
  localparam logic [1:0] OP_ADDR = 2'h0;
  localparam logic [1:0] OP_WR   = 2'h1;
  localparam logic [1:0] OP_RDI  = 2'h2;
  localparam logic [1:0] OP_RD   = 2'h3;
  localparam logic [4:0] DEVAD   = 5'h01;    // device address answered
  // device registers, mdio address space
  localparam logic [15:0] REG_CTRL  = 16'h0000;
  localparam logic [15:0] REG_STAT  = 16'h0001;
  localparam logic [15:0] REG_ALARM = 16'h0002;
  localparam logic [15:0] CTRL_RST  = 16'h0048; // alarm selects 0,1,2
  localparam int C_TXOFF = 0;                // software transmit off
  localparam int C_SEL1  = 1;                // alarm one source, 2 bits
  localparam int C_SEL2  = 3;                // alarm two source
  localparam int C_SEL3  = 5;                // alarm three source
  localparam int C_ROLE1 = 7;                // 1: control one unused
  localparam int C_ROLE23 = 8;               // 1: controls two/three unused
  // alarm source codes
  localparam logic [1:0] SRC_HPD   = 2'h0;
  localparam logic [1:0] SRC_READY = 2'h1;
  localparam logic [1:0] SRC_FAULT = 2'h2;
  localparam logic [1:0] SRC_LOS   = 2'h3;
  // host wishbone byte offsets
  localparam logic [3:0] HA_PINS  = 4'h0;
  localparam logic [3:0] HA_SENSE = 4'h4;
  localparam logic [3:0] HA_MCMD  = 4'h8;
  localparam logic [3:0] HA_MSTAT = 4'hC;
  localparam logic [10:0] PINS_RST = 11'h03B; // safe, in reset
endpackage : omc_pkg
`default_nettype wire

// ==== rtl/omc_if.sv ====
// Purpose: pin bundle between host board and module
// Assumes: host pull-ups on presence, alarm and mdio lines
// Notes:   open-drain and two-way lines resolved here
`default_nettype none
interface omc_if;
  logic       transmit_off_in;       // host to module
  logic       low_power_request_in;
  logic       module_reset_low_in;
  logic       prog_control_one;
  logic       prog_control_two;
  logic       prog_control_three;
  logic [4:0] mgmt_port_addr_in;
  logic       mdc;                   // host made management clock
  logic       prog_alarm_one;        // module to host
  logic       prog_alarm_two;
  logic       prog_alarm_three;
  logic       receive_signal_lost_out;
  logic       alarm_o;               // open drain, module side
  logic       alarm_oe;
  logic       presence_o;            // tied low in module
  logic       presence_oe;
  logic       mdio_dev_o;
  logic       mdio_dev_oe;
  logic       mdio_host_o;
  logic       mdio_host_oe;
  logic       any_alarm_low_out;     // resolved lines
  logic       presence_out;
  logic       mdio;
  // pull-ups give a high level when nobody drives
  assign any_alarm_low_out = alarm_oe ? alarm_o : 1'b1;
  assign presence_out = presence_oe ? presence_o : 1'b1;
  assign mdio = mdio_dev_oe ? mdio_dev_o :
                mdio_host_oe ? mdio_host_o : 1'b1;
  modport dev (
    input  transmit_off_in, low_power_request_in, module_reset_low_in,
    input  prog_control_one, prog_control_two, prog_control_three,
    input  mgmt_port_addr_in, mdc, mdio,
    output prog_alarm_one, prog_alarm_two, prog_alarm_three,
    output receive_signal_lost_out, alarm_o, alarm_oe,
    output presence_o, presence_oe, mdio_dev_o, mdio_dev_oe
  );
  modport host (
    output transmit_off_in, low_power_request_in, module_reset_low_in,
    output prog_control_one, prog_control_two, prog_control_three,
    output mgmt_port_addr_in, mdc, mdio_host_o, mdio_host_oe,
    input  prog_alarm_one, prog_alarm_two, prog_alarm_three,
    input  receive_signal_lost_out, any_alarm_low_out, presence_out, mdio
  );
endinterface : omc_if
`default_nettype wire

// ==== rtl/omc_dev.sv ====
// Purpose: module-side control pins and management slave
// Assumes: host keeps control levels for the least pulse width
// Notes:   outputs are registered; mdio answers after sync delay
`default_nettype none
module omc_dev
  import omc_pkg::*;
#(
  parameter int FILT_CYC = omc_pkg::CNTL_CYC - omc_pkg::FILT_MARGIN,
  parameter int INIT_CNT = omc_pkg::INIT_CYC
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  omc_if.dev                             pins,
  input  wire logic                      rx_weak_i,     // light too weak
  input  wire logic                      fault_i,       // module fault
  input  wire logic [omc_pkg::ALARMS-1:0] alarm_vec_i,  // alarm sources
  output logic [omc_pkg::LANES-1:0]      tx_enable_o,   // per lane
  output logic                           full_power_o,  // high power on
  output logic                           in_reset_o,    // module reset
  output logic                           trx_ic_reset_low_o,
  output logic [1:0]                     power_class_o, // 3 = 32 W
  output logic [4:0]                     port_addr_o
);
  import omc_pkg::*;

  localparam int FW = $clog2(FILT_CYC + 1);
  localparam int IW = $clog2(INIT_CNT + 1);
  // raw pins: ctl3, ctl2, ctl1, reset_low, low power, tx off
  localparam logic [5:0] OPEN_LVL = 6'h3B; // level when unconnected

  logic [5:0] raw;          // pin group
  logic [5:0] s1_q, s2_q;   // two-stage synchroniser
  logic [5:0] f_q;          // filtered levels
  logic [FW-1:0] cnt_q [6]; // per pin stability count
  logic [4:0] pa1_q;        // address synchroniser
  logic [IW-1:0] init_q;    // init timer
  logic       run_q;        // initialization done
  logic       mrst;         // module held in reset
  logic [15:0] ctrl_q;      // control register
  logic       hpd_q;        // high power done
  logic [2:0] mdc_q;        // mdc sync plus edge stage
  logic [1:0] mdi_q;        // mdio sync
  logic [5:0] ones_q;       // preamble ones seen
  logic [5:0] bit_q;        // bit index in frame, 0 = idle
  logic [15:0] sh_q;        // incoming bits
  logic [15:0] addr_q;      // register address
  logic [15:0] out_q;       // read data shifter
  logic       rd_q;         // current frame is a read for us
  logic       inc_q;        // post-read increment
  logic       wr_q;         // frame addressed to us
  logic [1:0] opc_q;        // opcode of frame
  logic       rise;         // mdc rising edge
  logic       bitv;         // sampled mdio bit
  logic       hit;          // header names our device and port
  logic [15:0] rdata;       // register read mux
  logic [3:0] src;          // alarm sources by code

  assign raw = {pins.prog_control_three, pins.prog_control_two,
                pins.prog_control_one, pins.module_reset_low_in,
                pins.low_power_request_in, pins.transmit_off_in};

  // synchronise pins before any logic reads them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= OPEN_LVL;
      s2_q <= OPEN_LVL;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end

  // glitch filter: a level must stand FILT_CYC cycles to count;
  // kept just under 100 us so transmit off still lands in time
  for (genvar i = 0; i < 6; i++) begin : g_filt
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        cnt_q[i] <= '0;
        f_q[i]   <= OPEN_LVL[i];
      end else if (s2_q[i] == f_q[i]) begin
        cnt_q[i] <= '0;
      end else if (cnt_q[i] == FW'(FILT_CYC - 1)) begin
        cnt_q[i] <= '0;
        f_q[i]   <= s2_q[i];
      end else begin
        cnt_q[i] <= cnt_q[i] + FW'(1);
      end
    end
  end

  assign mrst = rst_i | ~f_q[2];

  // init timer restarts on every module reset
  always_ff @(posedge clk_i) begin
    if (mrst) begin
      init_q <= '0;
      run_q  <= 1'b0;
    end else if (!run_q) begin
      init_q <= init_q + IW'(1);
      run_q  <= (init_q == IW'(INIT_CNT - 1));
    end
  end

  // port address pins are static straps but still synchronised
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pa1_q       <= '0;
      port_addr_o <= '0;
    end else begin
      pa1_q       <= pins.mgmt_port_addr_in;
      port_addr_o <= pa1_q;
    end
  end

  assign src = {rx_weak_i, fault_i, run_q, hpd_q};

  // module facing outputs, all registered
  always_ff @(posedge clk_i) begin
    if (mrst) begin
      tx_enable_o        <= '0;
      full_power_o       <= 1'b0;
      hpd_q              <= 1'b0;
      trx_ic_reset_low_o <= 1'b0;
      power_class_o      <= 2'h0;
    end else begin
      // tx off pin or software bit turns every lane off
      tx_enable_o  <= {LANES{run_q & ~f_q[0] & ~ctrl_q[C_TXOFF]}};
      full_power_o <= run_q & ~f_q[1];
      hpd_q        <= run_q & ~f_q[1];
      trx_ic_reset_low_o <= ctrl_q[C_ROLE1] | f_q[3];
      // unused role reads as the largest class
      power_class_o <= ctrl_q[C_ROLE23] ? 2'h3 : f_q[5:4];
    end
  end

  // pin outputs toward the host
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pins.prog_alarm_one   <= 1'b0;
      pins.prog_alarm_two   <= 1'b0;
      pins.prog_alarm_three <= 1'b0;
      pins.receive_signal_lost_out <= 1'b0;
      pins.alarm_oe         <= 1'b0;
    end else begin
      pins.prog_alarm_one   <= src[ctrl_q[C_SEL1 +: 2]];
      pins.prog_alarm_two   <= src[ctrl_q[C_SEL2 +: 2]];
      pins.prog_alarm_three <= src[ctrl_q[C_SEL3 +: 2]];
      pins.receive_signal_lost_out <= rx_weak_i;
      // one cycle, far inside the 150 ms bound
      pins.alarm_oe <= (|alarm_vec_i) | fault_i | rx_weak_i;
    end
  end

  assign pins.alarm_o     = 1'b0;  // open drain only pulls low
  assign pins.presence_o  = 1'b0;
  assign pins.presence_oe = 1'b1;
  assign in_reset_o       = ~f_q[2];

  // management clock from the host, edge found on system clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mdc_q <= 3'h0;
      mdi_q <= 2'h3;
    end else begin
      mdc_q <= {mdc_q[1:0], pins.mdc};
      mdi_q <= {mdi_q[0], pins.mdio};
    end
  end
  assign rise = mdc_q[1] & ~mdc_q[2];
  assign bitv = mdi_q[1];
  // valid while bit_q is 14: sh_q then holds ST, OP, PRT and DEV
  assign hit  = (sh_q[13:12] == 2'h0) && (sh_q[4:0] == DEVAD) &&
                (sh_q[9:5] == port_addr_o);

  // register read mux
  always_comb begin
    unique case (addr_q)
      REG_CTRL:  rdata = ctrl_q;
      REG_STAT:  rdata = {8'h00, power_class_o, rx_weak_i, fault_i,
                          run_q, hpd_q, f_q[1], f_q[0]};
      REG_ALARM: rdata = 16'(alarm_vec_i);
      default:   rdata = 16'h0000;  // unmapped reads zero
    endcase
  end

  // clause 45 frame: ST OP PRT DEV TA DATA, bit 0 is first ST bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ones_q <= '0;
      bit_q  <= '0;
      sh_q   <= '0;
      rd_q   <= 1'b0;
      inc_q  <= 1'b0;
      wr_q   <= 1'b0;
      opc_q  <= 2'h0;
      out_q  <= '0;
      addr_q <= '0;
      ctrl_q <= CTRL_RST;
      pins.mdio_dev_o  <= 1'b1;
      pins.mdio_dev_oe <= 1'b0;
    end else if (rise) begin
      sh_q <= {sh_q[14:0], bitv};
      if (bit_q == 6'd0) begin
        // idle: count preamble, a zero after 32 ones starts
        if (bitv) begin
          ones_q <= (ones_q == 6'(PRE_ONES)) ? ones_q : ones_q + 6'd1;
        end else begin
          if (ones_q == 6'(PRE_ONES)) bit_q <= 6'd1;
          ones_q <= '0;
        end
      end else begin
        bit_q <= (bit_q == 6'd31) ? 6'd0 : bit_q + 6'd1;
        if (bit_q == 6'd14) begin
          // header in sh_q[13:0]; a stray start bit leaves the frame ignored
          wr_q  <= hit;
          rd_q  <= hit && sh_q[11];
          opc_q <= sh_q[11:10];
          inc_q <= (sh_q[11:10] == OP_RDI);
          out_q <= rdata;
        end
        // each bit leaves on the rise before the one that samples it
        if (bit_q == 6'd14 && hit && sh_q[11]) begin
          pins.mdio_dev_oe <= 1'b1;  // second turnaround bit is zero
          pins.mdio_dev_o  <= 1'b0;
        end else if (bit_q >= 6'd15 && bit_q <= 6'd30 && rd_q) begin
          pins.mdio_dev_o <= out_q[15];
          out_q <= {out_q[14:0], 1'b0};
        end
        if (bit_q == 6'd31) begin
          pins.mdio_dev_oe <= 1'b0;
          pins.mdio_dev_o  <= 1'b1;
          rd_q <= 1'b0;
          if (wr_q && opc_q == OP_ADDR) addr_q <= {sh_q[14:0], bitv};
          if (wr_q && opc_q == OP_WR && addr_q == REG_CTRL) begin
            ctrl_q <= {sh_q[14:0], bitv};
          end
          if (wr_q && inc_q) addr_q <= addr_q + 16'h0001;
        end
      end
    end
  end

  // driving one rise early leaves a whole mdc period for the
  // host's two-flop sampling delay
endmodule : omc_dev
`default_nettype wire

// ==== rtl/omc_host.sv ====
// Purpose: host board controller for the module pins
// Assumes: classic wishbone master on the software side
// Notes:   mdc made by divider, runs only during a frame
`default_nettype none
module omc_host
  import omc_pkg::*;
#(
  parameter int HALF = omc_pkg::MDC_HALF
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  omc_if.host              pins,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o
);
  import omc_pkg::*;

  localparam int HW = $clog2(HALF + 1);
  logic [10:0] pins_q;      // control levels and port address
  logic [5:0]  s1_q, s2_q;  // sense synchroniser
  logic [1:0]  mdi_q;       // mdio synchroniser
  logic        busy_q;      // frame running
  logic [HW-1:0] div_q;     // mdc divider
  logic        mdc_q;       // mdc level
  logic [5:0]  idx_q;       // bit index 0..63
  logic [63:0] fr_q;        // outgoing frame
  logic        rdop_q;      // frame is a read
  logic [15:0] rdat_q;      // read data
  logic        req;         // bus request this cycle
  logic        tick;        // mdc half period over

  assign req  = cyc_i & stb_i & ~ack_o;
  assign tick = (div_q == HW'(HALF - 1));

  // pin levels from software register
  assign pins.transmit_off_in      = pins_q[0];
  assign pins.low_power_request_in = pins_q[1];
  assign pins.module_reset_low_in  = pins_q[2];
  assign pins.prog_control_one     = pins_q[3];
  assign pins.prog_control_two     = pins_q[4];
  assign pins.prog_control_three   = pins_q[5];
  assign pins.mgmt_port_addr_in    = pins_q[10:6];
  assign pins.mdc                  = mdc_q;

  // bus slave: answer one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o  <= 1'b0;
      dat_o  <= '0;
      pins_q <= PINS_RST;
    end else begin
      ack_o <= req;
      if (req && !we_i) begin
        unique case (adr_i)
          HA_PINS:  dat_o <= 32'(pins_q);
          HA_SENSE: dat_o <= 32'(s2_q);
          HA_MSTAT: dat_o <= {15'h0000, busy_q, rdat_q};
          default:  dat_o <= 32'h0000_0000;
        endcase
      end
      // levels held until software writes again, with no least hold time
      if (req && we_i && adr_i == HA_PINS && sel_i[0]) begin
        pins_q[7:0] <= dat_i[7:0];
      end
      if (req && we_i && adr_i == HA_PINS && sel_i[1]) begin
        pins_q[10:8] <= dat_i[10:8];
      end
    end
  end

  // sense pins through two flip-flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q  <= 6'h30;
      s2_q  <= 6'h30;
      mdi_q <= 2'h3;
    end else begin
      // absent/alarm lines pulled up when open
      s1_q  <= {pins.presence_out, pins.any_alarm_low_out,
                pins.receive_signal_lost_out, pins.prog_alarm_three,
                pins.prog_alarm_two, pins.prog_alarm_one};
      s2_q  <= s1_q;
      mdi_q <= {mdi_q[0], pins.mdio};
    end
  end

  // mdio master: change on mdc fall, sample on mdc rise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_q <= 1'b0;
      div_q  <= '0;
      mdc_q  <= 1'b0;
      idx_q  <= '0;
      fr_q   <= '0;
      rdop_q <= 1'b0;
      rdat_q <= '0;
      pins.mdio_host_o  <= 1'b1;
      pins.mdio_host_oe <= 1'b0;
    end else if (!busy_q) begin
      // a command written while busy is ignored
      if (req && we_i && adr_i == HA_MCMD && (&sel_i[2:0])) begin
        busy_q <= 1'b1;
        div_q  <= '0;
        idx_q  <= '0;
        rdop_q <= dat_i[22];
        fr_q   <= {32'hFFFF_FFFF, 2'h0, dat_i[22:21], pins_q[10:6],
                   dat_i[20:16], 2'h2, dat_i[15:0]};
        pins.mdio_host_o  <= 1'b1;
        pins.mdio_host_oe <= 1'b1;
      end
    end else begin
      div_q <= tick ? '0 : div_q + HW'(1);
      if (tick) begin
        mdc_q <= ~mdc_q;
        if (!mdc_q) begin
          // rising edge: data bits of a read sampled here
          if (rdop_q && idx_q >= 6'd48) rdat_q <= {rdat_q[14:0], mdi_q[1]};
        end else if (idx_q == 6'd63) begin
          busy_q <= 1'b0;
          pins.mdio_host_oe <= 1'b0;
          pins.mdio_host_o  <= 1'b1;
        end else begin
          idx_q <= idx_q + 6'd1;
          fr_q  <= {fr_q[62:0], 1'b1};
          pins.mdio_host_o  <= fr_q[62];
          // read: release from turnaround onward
          pins.mdio_host_oe <= ~(rdop_q && idx_q >= 6'd45);
        end
      end else if (div_q == '0 && mdc_q == 1'b0 && idx_q == '0) begin
        pins.mdio_host_o <= fr_q[63];
      end
    end
  end
endmodule : omc_host
`default_nettype wire

// ==== tb/omc_properties.sv ====
// Purpose: timing checks on the pins between host and module
// Assumes: small filter and init counts, mdc half period of 8 cycles
// Notes:   held sequences allow for sync, filter and output register
`default_nettype none
module omc_properties
  import omc_pkg::*;
(
  input wire logic                       clk_i,
  input wire logic                       rst_i,
  input wire logic                       low_power_request_in,
  input wire logic                       module_reset_low_in,
  input wire logic                       mdc,
  input wire logic                       prog_alarm_one,
  input wire logic                       prog_alarm_two,
  input wire logic                       prog_alarm_three,
  input wire logic                       receive_signal_lost_out,
  input wire logic                       alarm_o,
  input wire logic                       alarm_oe,
  input wire logic                       any_alarm_low_out,
  input wire logic                       presence_out,
  input wire logic                       mdio_dev_oe,
  input wire logic                       mdio_host_oe,
  input wire logic                       rx_weak_i,
  input wire logic                       fault_i,
  input wire logic [omc_pkg::ALARMS-1:0] alarm_vec_i
);
  timeunit 1ns;
  timeprecision 1ps;
  import omc_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // twelve cycles outlast filter of 4 plus sync and register
  sequence s_lp_held;
    low_power_request_in[*8] ##1 low_power_request_in[*4];
  endsequence
  sequence s_rst_held;
    !module_reset_low_in[*8] ##1 !module_reset_low_in[*4];
  endsequence
  property p_presence; presence_out == 1'b0; endproperty
  a_presence: assert property (p_presence)
    else $error("presence line not low");
  property p_open_drain; alarm_oe |-> !alarm_o; endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("global alarm driven high");
  property p_no_clash; !(mdio_dev_oe && mdio_host_oe); endproperty
  a_no_clash: assert property (p_no_clash)
    else $error("both ends drive mdio");
  property p_mdc_high; $rose(mdc) |-> mdc[*8] ##1 !mdc; endproperty
  a_mdc_high: assert property (p_mdc_high)
    else $error("mdc high phase wrong");
  property p_lp; s_lp_held |-> !prog_alarm_one; endproperty
  a_lp: assert property (p_lp)
    else $error("high power done in low power");
  property p_rst; s_rst_held |-> !prog_alarm_two && !prog_alarm_one;
  endproperty
  a_rst: assert property (p_rst)
    else $error("ready while module held in reset");
  property p_los_on; rx_weak_i[*3] |-> receive_signal_lost_out; endproperty
  a_los_on: assert property (p_los_on)
    else $error("loss of signal not raised");
  property p_los_off; !rx_weak_i[*3] |-> !receive_signal_lost_out;
  endproperty
  a_los_off: assert property (p_los_off)
    else $error("loss of signal raised without cause");
  property p_fault; fault_i[*3] |-> prog_alarm_three && !any_alarm_low_out;
  endproperty
  a_fault: assert property (p_fault)
    else $error("fault not shown on alarms");
  property p_quiet;
    (!fault_i && !rx_weak_i && alarm_vec_i == '0)[*3] |-> any_alarm_low_out;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("global alarm low without cause");
endmodule : omc_properties
`default_nettype wire

// ==== tb/tb_top.sv ====
// Purpose: joins host controller and module, drives both user sides
// Assumes: port address 5 on the pins, default alarm roles kept
// Notes:   short filter and init counts keep the run small
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import omc_pkg::*;
  logic        clk_i, rst_i, cyc, stb, we, ack, rx_weak, fault;
  logic        full_pw, in_rst, trx_low;
  logic [3:0]  adr, sel, tx_en;
  logic [31:0] dat_w, dat_r, r;
  logic [7:0]  alarm_vec;
  logic [1:0]  pclass;
  logic [4:0]  paddr;
  int          failures, compares, cycles;
  logic [9:0]  stim [4] = '{10'h100, 10'h080, 10'h200, 10'h000};
  logic [5:0]  sexp [4] = '{6'h07, 6'h03, 6'h0B, 6'h13};
  omc_if i_omc_if ();
  omc_dev #(.FILT_CYC(4), .INIT_CNT(20)) i_omc_dev (.clk_i(clk_i),
    .rst_i(rst_i), .pins(i_omc_if.dev), .rx_weak_i(rx_weak),
    .fault_i(fault), .alarm_vec_i(alarm_vec), .tx_enable_o(tx_en),
    .full_power_o(full_pw), .in_reset_o(in_rst),
    .trx_ic_reset_low_o(trx_low), .power_class_o(pclass),
    .port_addr_o(paddr));
  omc_host #(.HALF(8)) i_omc_host (.clk_i(clk_i), .rst_i(rst_i),
    .pins(i_omc_if.host), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack));
  omc_properties i_omc_properties (.clk_i(clk_i), .rst_i(rst_i),
    .low_power_request_in(i_omc_if.low_power_request_in),
    .module_reset_low_in(i_omc_if.module_reset_low_in),
    .mdc(i_omc_if.mdc), .prog_alarm_one(i_omc_if.prog_alarm_one),
    .prog_alarm_two(i_omc_if.prog_alarm_two),
    .prog_alarm_three(i_omc_if.prog_alarm_three),
    .receive_signal_lost_out(i_omc_if.receive_signal_lost_out),
    .alarm_o(i_omc_if.alarm_o), .alarm_oe(i_omc_if.alarm_oe),
    .any_alarm_low_out(i_omc_if.any_alarm_low_out),
    .presence_out(i_omc_if.presence_out),
    .mdio_dev_oe(i_omc_if.mdio_dev_oe),
    .mdio_host_oe(i_omc_if.mdio_host_oe), .rx_weak_i(rx_weak),
    .fault_i(fault), .alarm_vec_i(alarm_vec));
  // free running clock, 20 ns period
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // verdict, reached from the main sequence or the watchdog
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done
  // watchdog; seven management frames need about 7500 cycles
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      test_done();
    end
  end
  task automatic check(input string n, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      failures++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask : check
  // classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  // one management frame, polled until busy clears
  task automatic mgmt(input logic [1:0] op, input logic [4:0] dv,
                      input logic [15:0] d, output logic [31:0] s);
    wb(1'b1, HA_MCMD, {9'h000, op, dv, d}, s);
    s = 32'h00010000;
    while (s[16] !== 1'b0) wb(1'b0, HA_MSTAT, 32'h0, s);
  endtask : mgmt
  // main sequence
  initial begin
    {cyc, stb, we, rx_weak, fault, alarm_vec} = '0;
    {adr, dat_w, failures, compares, cycles} = '0;
    sel = 4'hF;
    rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, HA_PINS, 32'h0, r);
    check("pins after reset", r, 32'(PINS_RST));
    check("lanes in reset", 32'(tx_en), 32'h0);
    check("module in reset", 32'(in_rst), 32'h1);
    wb(1'b0, HA_SENSE, 32'h0, r);
    check("sense in reset", r & 32'h3F, 32'h10);
    wb(1'b1, HA_PINS, 32'h17C, r);
    repeat (60) @(posedge clk_i);
    check("lanes on", 32'(tx_en), 32'hF);
    check("full power", 32'(full_pw), 32'h1);
    check("module running", 32'(in_rst), 32'h0);
    check("trx reset off", 32'(trx_low), 32'h1);
    check("port address", 32'(paddr), 32'h5);
    wb(1'b0, HA_SENSE, 32'h0, r);
    check("sense running", r & 32'h3F, 32'h13);
    for (int k = 0; k < 4; k++) begin
      wb(1'b1, HA_PINS, 32'h14C | (32'(k) << 4), r);
      repeat (20) @(posedge clk_i);
      check("power class", 32'(pclass), 32'(k));
    end
    wb(1'b1, HA_PINS, 32'h174, r);
    wb(1'b1, HA_PINS, 32'h17C, r);
    repeat (20) @(posedge clk_i);
    check("short pulse kept out", 32'(trx_low), 32'h1);
    wb(1'b1, HA_PINS, 32'h144, r);
    repeat (20) @(posedge clk_i);
    check("trx reset on", 32'(trx_low), 32'h0);
    mgmt(OP_ADDR, DEVAD, REG_CTRL, r);
    mgmt(OP_WR, DEVAD, 16'h01C9, r);
    check("control one reassigned", 32'(trx_low), 32'h1);
    check("controls two three reassigned", 32'(pclass), 32'h3);
    check("software transmit off", 32'(tx_en), 32'h0);
    mgmt(OP_RDI, DEVAD, 16'h0000, r);
    check("control read back", r & 32'hFFFF, 32'h01C9);
    mgmt(OP_RD, DEVAD, 16'h0000, r);
    check("status after increment", r & 32'hFFFF, 32'h00CC);
    mgmt(OP_ADDR, DEVAD, 16'h0010, r);
    mgmt(OP_RD, DEVAD, 16'h0000, r);
    check("unmapped read", r & 32'hFFFF, 32'h0);
    mgmt(OP_RD, 5'h02, 16'h0000, r);
    check("other device silent", r & 32'hFFFF, 32'hFFFF);
    for (int i = 0; i < 4; i++) begin
      {rx_weak, fault, alarm_vec} <= stim[i];
      repeat (6) @(posedge clk_i);
      wb(1'b0, HA_SENSE, 32'h0, r);
      check("alarm outputs", r & 32'h3F, 32'(sexp[i]));
    end
    wb(1'b1, HA_PINS, 32'h17B, r);
    repeat (40) @(posedge clk_i);
    check("lanes off", 32'(tx_en), 32'h0);
    check("low power", 32'(full_pw), 32'h0);
    check("module reset", 32'(in_rst), 32'h1);
    wb(1'b0, HA_SENSE, 32'h0, r);
    check("sense after reset pin", r & 32'h3F, 32'h10);
    test_done();
  end
endmodule : tb_top
`default_nettype wire
